/* File: bench/lsd_glass_model.sv */
/*
  Passive glass: reports the drive step across segment lines 0 and 1
  against common 0. Assumes level codes are evenly spaced steps.
*/
`timescale 1ns/100ps
`default_nettype none

module lsd_glass_model (
    // Driver pins.
    input wire logic [79:0] segmentLinesLvl,
    input wire logic [39:0] segmentLinesOe,
    input wire logic [7:0] commonLinesLvl,
    input wire logic [3:0] commonLinesOe,
    // Cell voltages in level steps.
    output logic [1:0] across0,
    output logic [1:0] across1
);
    function automatic logic [1:0] span(input logic [1:0] a, input logic [1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    // A floating electrode leaves no field across the cell.
    assign across0 = (segmentLinesOe[0] && commonLinesOe[0]) ?
        span(segmentLinesLvl[1:0], commonLinesLvl[1:0]) : 2'h0;
    assign across1 = (segmentLinesOe[1] && commonLinesOe[0]) ?
        span(segmentLinesLvl[3:2], commonLinesLvl[1:0]) : 2'h0;
endmodule
`default_nettype wire

/* File: bench/lsd_props.sv */
/*
  Checker of the segment display driver, bound to its top module.
  Assumes the master writes every byte lane of the control registers.
*/
`timescale 1ns/100ps
`default_nettype none

module lsd_props
    import lsd_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clock,
    input wire logic nrst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Slow clock, low-power requests and pins.
    input wire logic slow_source_clock,
    input wire logic waitMode,
    input wire logic stopMode,
    input wire logic [79:0] segmentLinesLvl,
    input wire logic [39:0] segmentLinesOe,
    input wire logic [7:0] commonLinesLvl,
    input wire logic [3:0] commonLinesOe
);
    logic [7:0] ctrl0_q;
    logic halt_q;
    logic [39:0] segEn_q;
    logic take;
    logic dispOn;
    logic haltReq;
    logic [3:0] activeComs;

    assign take = cyc_i & stb_i & we_i & ~ack_o;
    assign dispOn = ctrl0_q[LSD_DISPON_BIT];
    assign haltReq = stopMode | (waitMode & halt_q);
    assign activeComs = (ctrl0_q[1:0] == LSD_DUTY_1_4) ? 4'hF :
        4'((5'h01 << ctrl0_q[1:0]) - 5'h01);

    // Shadow of the control registers, updated at the edge that takes a write.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q <= 8'h00;
            halt_q <= 1'b0;
            segEn_q <= 40'h00_0000_0000;
        end else if (take) begin
            if (adr_i == LSD_OFF_CTRL0) ctrl0_q <= dat_i[7:0];
            if (adr_i == LSD_OFF_CTRL1) halt_q <= dat_i[LSD_HALTWAIT_BIT];
            if (adr_i == LSD_OFF_SEGEN_LO) segEn_q[31:0] <= dat_i;
            if (adr_i == LSD_OFF_SEGEN_HI) segEn_q[39:32] <= dat_i[7:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence haltHeld;
        (haltReq && dispOn)[*3];
    endsequence

    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack stood longer than one cycle");
    a_ack_answers: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not acknowledged in one cycle");
    a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without a request");
    a_data_quiet: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside the ack cycle");
    a_seg_oe_track: assert property (
        segmentLinesOe == ($past(dispOn) ? $past(segEn_q) : 40'h00_0000_0000))
        else $error("segment enable pins disagree with controls");
    a_com_oe_track: assert property (
        commonLinesOe == ($past(dispOn, 2) ? $past(activeComs) : 4'h0))
        else $error("common enable pins disagree with duty");
    a_halt_pulls_low: assert property (haltHeld |=>
        (segmentLinesLvl == 80'h0 && commonLinesLvl == 8'h00))
        else $error("halted pins not pulled low");
    a_two_levels: assert property ((dispOn && $past(ctrl0_q[1:0]) == LSD_DUTY_1_1) |->
        (commonLinesLvl[1] == commonLinesLvl[0] && segmentLinesLvl[1] == segmentLinesLvl[0]))
        else $error("mid level used at full bias");
endmodule

bind lsd_segment_driver lsd_props props_u (.clock(clock), .nrst(nrst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .slow_source_clock(slow_source_clock), .waitMode(waitMode),
    .stopMode(stopMode), .segmentLinesLvl(segmentLinesLvl), .segmentLinesOe(segmentLinesOe),
    .commonLinesLvl(commonLinesLvl), .commonLinesOe(commonLinesOe));
`default_nettype wire

/* File: bench/test_lsd_segment_driver.sv */
/*
  Testbench of the segment display driver over classic Wishbone.
  Assumes a free-running slow clock of four system clocks per period.
*/
`timescale 1ns/100ps
`default_nettype none

module test_lsd_segment_driver;
    import lsd_pkg::*;
    logic clock, nrst, cyc_i, stb_i, we_i, ack_o, slow_source_clock, waitMode, stopMode;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [79:0] segmentLinesLvl;
    logic [39:0] segmentLinesOe;
    logic [7:0] commonLinesLvl;
    logic [3:0] commonLinesOe;
    logic [1:0] across0, across1;
    logic sawMid;
    int n_errors, checked;
    logic [7:0] modes [4] = '{8'h02, 8'h06, 8'h03, 8'h00};
    int ncoms [4] = '{2, 2, 3, 4};

    lsd_segment_driver dut_u (.clock(clock), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .slow_source_clock(slow_source_clock), .waitMode(waitMode), .stopMode(stopMode),
        .segmentLinesLvl(segmentLinesLvl), .segmentLinesOe(segmentLinesOe),
        .commonLinesLvl(commonLinesLvl), .commonLinesOe(commonLinesOe));
    lsd_glass_model glass_u (.segmentLinesLvl(segmentLinesLvl),
        .segmentLinesOe(segmentLinesOe), .commonLinesLvl(commonLinesLvl),
        .commonLinesOe(commonLinesOe), .across0(across0), .across1(across1));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        slow_source_clock = 1'b0;
        #3;
        forever #16 slow_source_clock = ~slow_source_clock;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    // Clocks between the 2nd and 3rd rise of common 0 to full level.
    task automatic period(input int want);
        int n, t0, rises;
        logic prev;
        n = 0;
        t0 = 0;
        rises = 0;
        prev = 1'b1;
        sawMid = 1'b0;
        while (rises < 3 && n < 40000) begin
            @(posedge clock);
            n++;
            if (commonLinesLvl[1:0] === LSD_LVL_V2) sawMid = 1'b1;
            if (commonLinesLvl[1:0] === LSD_LVL_V3 && !prev) begin
                rises++;
                if (rises == 2) t0 = n;
            end
            prev = (commonLinesLvl[1:0] === LSD_LVL_V3);
        end
        chk(32'(n - t0), 32'(want));
    endtask

    initial begin
        #(80000 * 8);
        n_errors++;
        close_out();
    end

    initial begin
        n_errors = 0;
        checked = 0;
        {nrst, cyc_i, stb_i, we_i, waitMode, stopMode} = 6'h00;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0000_0000;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rdc(LSD_OFF_CTRL0, 32'h0000_0000);
        rdc(LSD_OFF_STATUS, 32'h0000_0400);
        rdc(LSD_OFF_CTRL1, 32'h0000_0000);
        rdc(LSD_OFF_SEGEN_LO, 32'h0000_0000);
        rdc(LSD_OFF_SEGEN_HI, 32'h0000_0000);
        chk({segmentLinesOe[31:0]}, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < LSD_RAM_WORDS; i++) wb(1'b1, LSD_OFF_RAM0 + 8'(4 * i), 32'hA5C3_0F00 ^ 32'(i));
        for (int i = 0; i < LSD_RAM_WORDS; i++) rdc(LSD_OFF_RAM0 + 8'(4 * i), 32'hA5C3_0F00 ^ 32'(i));
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0000_0000);
        $display("test storage done");
        wb(1'b1, LSD_OFF_RAM0, 32'h0000_0001);
        wb(1'b1, LSD_OFF_CTRL0, 32'h0000_0005);
        wb(1'b1, LSD_OFF_SEGEN_LO, 32'h0000_0003);
        repeat (20) @(posedge clock);
        chk({30'h0, segmentLinesOe[1:0]}, 32'h0000_0000);
        wb(1'b1, LSD_OFF_CTRL0, 32'h0000_0085);
        rdc(LSD_OFF_RAM0, 32'h0000_0001);
        rdc(LSD_OFF_RAM0 + 8'h04, 32'hA5C3_0F01);
        repeat (100) @(posedge clock);
        chk({30'h0, across0}, 32'h0000_0003);
        chk({30'h0, across1}, 32'h0000_0000);
        wb(1'b1, LSD_OFF_SEGEN_LO, 32'h0000_0007);
        repeat (2) @(posedge clock);
        chk(segmentLinesOe[31:0], 32'h0000_0007);
        $display("test waveform done");
        waitMode <= 1'b1;
        period(512);
        wb(1'b1, LSD_OFF_CTRL1, 32'h0000_0001);
        repeat (5) @(posedge clock);
        chk({segmentLinesLvl[5:0], commonLinesLvl[1:0]}, 32'h0000_0000);
        chk(segmentLinesOe[31:0], 32'h0000_0007);
        rdc(LSD_OFF_CTRL1, 32'h0000_0001);
        waitMode <= 1'b0;
        period(512);
        wb(1'b1, LSD_OFF_CTRL1, 32'h0000_0000);
        stopMode <= 1'b1;
        repeat (5) @(posedge clock);
        chk({segmentLinesLvl[5:0], commonLinesLvl[1:0]}, 32'h0000_0000);
        stopMode <= 1'b0;
        period(512);
        $display("test low power done");
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, LSD_OFF_CTRL0, 32'h0000_0081 | (32'(p) << LSD_PRESC_LSB));
            period(512 << p);
        end
        $display("test prescaler done");
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, LSD_OFF_CTRL0, 32'(modes[m]));
            repeat (20) @(posedge clock);
            wb(1'b1, LSD_OFF_CTRL0, 32'(modes[m]) | 32'h0000_0080);
            period(512 * ncoms[m]);
            chk({31'h0, sawMid}, {31'h0, modes[m] != 8'h02});
        end
        $display("test duty done");
        close_out();
    end
endmodule
`default_nettype wire

/* File: shared/lsd_pkg.sv */
/*
  Package of the segment display driver: register offsets, field positions,
  reset values, mode encodings, drive level codes and the run states.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package lsd_pkg;

    // Register byte offsets.
    localparam logic [7:0] LSD_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] LSD_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] LSD_OFF_SEGEN_LO = 8'h08;
    localparam logic [7:0] LSD_OFF_SEGEN_HI = 8'h0C;
    localparam logic [7:0] LSD_OFF_STATUS = 8'h10;
    localparam logic [7:0] LSD_OFF_RAM0 = 8'h20;
    localparam int LSD_RAM_WORDS = 5;

    // Internal register selector codes returned by the address decoder.
    localparam logic [3:0] LSD_SEL_CTRL0 = 4'h0;
    localparam logic [3:0] LSD_SEL_CTRL1 = 4'h1;
    localparam logic [3:0] LSD_SEL_SEGEN_LO = 4'h2;
    localparam logic [3:0] LSD_SEL_SEGEN_HI = 4'h3;
    localparam logic [3:0] LSD_SEL_STATUS = 4'h4;
    localparam logic [3:0] LSD_SEL_RAM0 = 4'h8;
    localparam logic [3:0] LSD_SEL_NONE = 4'hF;

    // Field positions in display_control_0.
    localparam int LSD_DUTY_LSB = 0;
    localparam int LSD_BIAS_BIT = 2;
    localparam int LSD_PRESC_LSB = 4;
    localparam int LSD_DISPON_BIT = 7;
    // Field position in display_control_1.
    localparam int LSD_HALTWAIT_BIT = 0;
    // Field positions in the status register.
    localparam int LSD_ST_PHASE_LSB = 0;
    localparam int LSD_ST_INV_BIT = 2;
    localparam int LSD_ST_RUN_LSB = 4;
    localparam int LSD_ST_NCOM_LSB = 8;

    // Duty (multiplex ratio) encodings.
    localparam logic [1:0] LSD_DUTY_1_4 = 2'h0;
    localparam logic [1:0] LSD_DUTY_1_1 = 2'h1;
    localparam logic [1:0] LSD_DUTY_1_2 = 2'h2;
    localparam logic [1:0] LSD_DUTY_1_3 = 2'h3;

    // Prescaler dividers, indexed by clock_prescale_sel.
    localparam logic [9:0] LSD_DIV_SEL0 = 10'h040;
    localparam logic [9:0] LSD_DIV_SEL1 = 10'h080;
    localparam logic [9:0] LSD_DIV_SEL2 = 10'h100;
    localparam logic [9:0] LSD_DIV_SEL3 = 10'h200;

    // Reset values.
    localparam logic [1:0] LSD_RST_DUTY = LSD_DUTY_1_4;
    localparam logic LSD_RST_BIAS = 1'b0;
    localparam logic [1:0] LSD_RST_PRESC = 2'h0;
    localparam logic LSD_RST_DISPON = 1'b0;
    localparam logic LSD_RST_HALTWAIT = 1'b0;
    localparam logic [39:0] LSD_RST_SEGEN = 40'h00_0000_0000;

    // Drive level codes: V0 is ground, V3 the full drive supply.
    localparam logic [1:0] LSD_LVL_V0 = 2'h0;
    localparam logic [1:0] LSD_LVL_V1 = 2'h1;
    localparam logic [1:0] LSD_LVL_V2 = 2'h2;
    localparam logic [1:0] LSD_LVL_V3 = 2'h3;

    typedef enum logic [1:0] {
        LSD_BIAS_1_1 = 2'b00,
        LSD_BIAS_1_2 = 2'b01,
        LSD_BIAS_1_3 = 2'b10
    } lsd_bias_t;

    typedef enum logic [1:0] {
        LSD_RUN_OFF = 2'b00,
        LSD_RUN_ACTIVE = 2'b01,
        LSD_RUN_HALT = 2'b10
    } lsd_run_t;

endpackage

/* File: src/lsd_segment_driver.sv */
/*
  Segment display driver: 40 segment lines multiplexed against up to four
  common lines, with a 160-bit segment memory and control registers on a
  classic Wishbone slave.
  Assumes waitMode and stopMode come from logic on the same clock, and that
  slow_source_clock is a free-running pin clock far slower than clock; it is
  synchronised and edge-detected here.
  Each pin is presented as a drive level code plus an output enable; the
  analog level switches outside turn codes into voltages.
*/
// Added by the designer: the placing of the registers and register access over Wishbone.
// How it works
// [R1] Reset selects quarter duty, third bias.
// [R2] Reset clears enables and display_on; pins float.
// [R3] Prescale select divides slow clock 64..512.
// [R4] One display-clock period per active common.
// [R5] 160 memory bits; one turns segment on.
// [R6] Zero bit drives segment off waveform.
// [R7] Bus reads memory anytime while display runs.
// [R8] Display off: memory is plain storage.
// [R9] display_on access leaves memory untouched.
// [R10] Memory need not be cleared at reset.
// [R11] Enable without display_on gives no waveform.
// [R12] With display_on, enable starts waveform immediately.
// [R13] Duty code selects one to four commons.
// [R14] Bias follows duty; bias bit at half duty.
// [R15] Two, three or four drive levels by bias.
// [R16] Common waveforms fixed, independent of memory.
// [R17] Segment waveform from its bits per common.
// [R18] Unused commons stay high impedance.
// [R19] Halt bit clear: run through wait mode.
// [R20] Halt bit set: wait stops, enabled pins low.
// [R21] Wait shutdown keeps memory and registers.
// [R22] Stop mode halts, pulls low, retains state.
// [R23] Disabled segment line stays high impedance.
`timescale 1ns/100ps
`default_nettype none

module lsd_segment_driver
    import lsd_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Slow display clock pin and low-power requests.
    input wire logic slow_source_clock,
    input wire logic waitMode,
    input wire logic stopMode,
    // Segment line drivers: two level bits per line.
    output logic [79:0] segmentLinesLvl,
    output logic [39:0] segmentLinesOe,
    // Common line drivers: two level bits per line.
    output logic [7:0] commonLinesLvl,
    output logic [3:0] commonLinesOe
);
    import lsd_pkg::*;

    typedef struct packed {
        logic displayOn;
        logic [1:0] duty;
        logic biasSel;
        logic [1:0] prescale;
        logic haltInWait;
        logic [39:0] segEn;
        logic [159:0] ram;
        logic [2:0] slowSync;
        logic [9:0] preCnt;
        logic [1:0] phase;
        logic frameInv;
        lsd_run_t run;
        logic ack;
        logic [31:0] rdData;
        logic [79:0] segLvl;
        logic [39:0] segOe;
        logic [7:0] comLvl;
        logic [3:0] comOe;
    } lsd_state_t;

    // The segment memory is cleared as well, although software must not rely on it.
    localparam lsd_state_t LSD_STATE_RST = '{
        displayOn: LSD_RST_DISPON,
        duty: LSD_RST_DUTY,
        biasSel: LSD_RST_BIAS,
        prescale: LSD_RST_PRESC,
        haltInWait: LSD_RST_HALTWAIT,
        segEn: LSD_RST_SEGEN,
        ram: '0,
        slowSync: 3'h0,
        preCnt: 10'h000,
        phase: 2'h0,
        frameInv: 1'b0,
        run: LSD_RUN_OFF,
        ack: 1'b0,
        rdData: 32'h0000_0000,
        segLvl: 80'h0,
        segOe: 40'h00_0000_0000,
        comLvl: 8'h00,
        comOe: 4'h0
    };

    lsd_state_t s_q;
    lsd_state_t s_d;

    // Maps a bus address onto a register selector.
    function automatic logic [3:0] regSel(input logic [7:0] adr);
        logic [7:0] ramRel;
        ramRel = adr - LSD_OFF_RAM0;
        if (adr[1:0] != 2'h0) begin
            regSel = LSD_SEL_NONE;
        end else if (adr == LSD_OFF_CTRL0) begin
            regSel = LSD_SEL_CTRL0;
        end else if (adr == LSD_OFF_CTRL1) begin
            regSel = LSD_SEL_CTRL1;
        end else if (adr == LSD_OFF_SEGEN_LO) begin
            regSel = LSD_SEL_SEGEN_LO;
        end else if (adr == LSD_OFF_SEGEN_HI) begin
            regSel = LSD_SEL_SEGEN_HI;
        end else if (adr == LSD_OFF_STATUS) begin
            regSel = LSD_SEL_STATUS;
        end else if (adr >= LSD_OFF_RAM0 && ramRel[7:2] < 6'(LSD_RAM_WORDS)) begin
            regSel = LSD_SEL_RAM0 + {1'b0, ramRel[4:2]};
        end else begin
            regSel = LSD_SEL_NONE;
        end
    endfunction

    // Replaces only the byte lanes whose select is high.
    function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
        mergeSel = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                mergeSel[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
    endfunction

    // Number of commons in use for a duty code.
    // [R13] duty decode drives outputs
    function automatic logic [2:0] comCount(input logic [1:0] duty);
        case (duty)
            LSD_DUTY_1_1: comCount = 3'd1;
            LSD_DUTY_1_2: comCount = 3'd2;
            LSD_DUTY_1_3: comCount = 3'd3;
            default: comCount = 3'd4;
        endcase
    endfunction

    // Bias forced by the duty; the bias bit only matters at half duty.
    // [R14] bias choice drives outputs
    function automatic lsd_bias_t biasOf(input logic [1:0] duty, input logic biasSel);
        case (duty)
            LSD_DUTY_1_1: biasOf = LSD_BIAS_1_1;
            LSD_DUTY_1_2: biasOf = biasSel ? LSD_BIAS_1_3 : LSD_BIAS_1_2;
            default: biasOf = LSD_BIAS_1_3;
        endcase
    endfunction

    // Terminal count of the prescaler for a select code.
    function automatic logic [9:0] divTerm(input logic [1:0] sel);
        case (sel)
            2'h0: divTerm = LSD_DIV_SEL0 - 10'd1;
            2'h1: divTerm = LSD_DIV_SEL1 - 10'd1;
            2'h2: divTerm = LSD_DIV_SEL2 - 10'd1;
            default: divTerm = LSD_DIV_SEL3 - 10'd1;
        endcase
    endfunction

    // Common level: full swing when selected, bias level otherwise.
    function automatic logic [1:0] comLevel(input logic active, input logic inv,
                                            input lsd_bias_t bias);
        if (active) begin
            comLevel = inv ? LSD_LVL_V0 : LSD_LVL_V3;
        end else if (bias == LSD_BIAS_1_3) begin
            comLevel = inv ? LSD_LVL_V2 : LSD_LVL_V1;
        end else if (bias == LSD_BIAS_1_2) begin
            comLevel = LSD_LVL_V1;
        end else begin
            comLevel = inv ? LSD_LVL_V0 : LSD_LVL_V3;
        end
    endfunction

    // Segment level: opposite of the selected common when on.
    function automatic logic [1:0] segLevel(input logic on, input logic inv,
                                            input lsd_bias_t bias);
        if (on) begin
            segLevel = inv ? LSD_LVL_V3 : LSD_LVL_V0;
        end else if (bias == LSD_BIAS_1_3) begin
            segLevel = inv ? LSD_LVL_V1 : LSD_LVL_V2;
        end else begin
            segLevel = inv ? LSD_LVL_V0 : LSD_LVL_V3;
        end
    endfunction

    logic [3:0] accSel;
    logic access;
    logic slowEdge;
    logic haltReq;
    logic dispTick;
    logic [2:0] nCom;
    lsd_bias_t bias;
    logic segEnabled;
    logic segBit;
    logic [7:0] phaseBase;

    always_comb begin
        s_d = s_q;
        accSel = regSel(adr_i);
        access = cyc_i & stb_i & ~s_q.ack;
        nCom = comCount(s_q.duty);
        bias = biasOf(s_q.duty, s_q.biasSel);
        segEnabled = 1'b0;
        segBit = 1'b0;
        phaseBase = 8'h00;

        // Bus slave: one wait state, ack drops the cycle after it was given.
        s_d.ack = access;
        s_d.rdData = 32'h0000_0000;
        if (access && !we_i) begin
            case (accSel)
                LSD_SEL_CTRL0: begin
                    s_d.rdData[LSD_DUTY_LSB +: 2] = s_q.duty;
                    s_d.rdData[LSD_BIAS_BIT] = s_q.biasSel;
                    s_d.rdData[LSD_PRESC_LSB +: 2] = s_q.prescale;
                    s_d.rdData[LSD_DISPON_BIT] = s_q.displayOn;
                end
                LSD_SEL_CTRL1: s_d.rdData[LSD_HALTWAIT_BIT] = s_q.haltInWait;
                LSD_SEL_SEGEN_LO: s_d.rdData = s_q.segEn[31:0];
                LSD_SEL_SEGEN_HI: s_d.rdData[7:0] = s_q.segEn[39:32];
                LSD_SEL_STATUS: begin
                    s_d.rdData[LSD_ST_PHASE_LSB +: 2] = s_q.phase;
                    s_d.rdData[LSD_ST_INV_BIT] = s_q.frameInv;
                    s_d.rdData[LSD_ST_RUN_LSB +: 2] = s_q.run;
                    s_d.rdData[LSD_ST_NCOM_LSB +: 3] = nCom;
                end
                LSD_SEL_NONE: s_d.rdData = 32'h0000_0000;
                default: begin
                    // [R7] readback any time
                    s_d.rdData = s_q.ram[(accSel - LSD_SEL_RAM0) * 32 +: 32];
                end
            endcase
        end
        if (access && we_i) begin
            case (accSel)
                LSD_SEL_CTRL0: begin
                    if (sel_i[0]) begin
                        // [R9] control only, memory untouched
                        s_d.duty = dat_i[LSD_DUTY_LSB +: 2];
                        s_d.biasSel = dat_i[LSD_BIAS_BIT];
                        s_d.prescale = dat_i[LSD_PRESC_LSB +: 2];
                        s_d.displayOn = dat_i[LSD_DISPON_BIT];
                    end
                end
                LSD_SEL_CTRL1: begin
                    if (sel_i[0]) begin
                        s_d.haltInWait = dat_i[LSD_HALTWAIT_BIT];
                    end
                end
                LSD_SEL_SEGEN_LO: s_d.segEn[31:0] = mergeSel(s_q.segEn[31:0], dat_i, sel_i);
                LSD_SEL_SEGEN_HI: begin
                    if (sel_i[0]) begin
                        s_d.segEn[39:32] = dat_i[7:0];
                    end
                end
                LSD_SEL_STATUS: s_d.segEn = s_q.segEn;
                LSD_SEL_NONE: s_d.segEn = s_q.segEn;
                default: begin
                    // [R8] plain storage writes
                    s_d.ram[(accSel - LSD_SEL_RAM0) * 32 +: 32] =
                        mergeSel(s_q.ram[(accSel - LSD_SEL_RAM0) * 32 +: 32], dat_i, sel_i);
                end
            endcase
        end

        // Slow clock synchroniser and rising edge detector.
        s_d.slowSync = {s_q.slowSync[1:0], slow_source_clock};
        slowEdge = s_q.slowSync[1] & ~s_q.slowSync[2];

        // [R20] halt in wait
        // [R22] stop halts
        // [R19] wait alone does not halt
        haltReq = (waitMode & s_q.haltInWait) | stopMode;

        case (s_q.run)
            LSD_RUN_OFF: begin
                if (s_q.displayOn) begin
                    s_d.run = haltReq ? LSD_RUN_HALT : LSD_RUN_ACTIVE;
                end
            end
            LSD_RUN_ACTIVE: begin
                if (!s_q.displayOn) begin
                    s_d.run = LSD_RUN_OFF;
                end else if (haltReq) begin
                    s_d.run = LSD_RUN_HALT;
                end
            end
            LSD_RUN_HALT: begin
                // [R21] resume with retained state
                if (!haltReq) begin
                    s_d.run = s_q.displayOn ? LSD_RUN_ACTIVE : LSD_RUN_OFF;
                end
            end
            default: s_d.run = LSD_RUN_OFF;
        endcase

        // [R3] prescaler
        dispTick = 1'b0;
        if (s_q.run == LSD_RUN_OFF) begin
            s_d.preCnt = 10'h000;
            s_d.phase = 2'h0;
            s_d.frameInv = 1'b0;
        end else if (s_q.run == LSD_RUN_ACTIVE && slowEdge) begin
            if (s_q.preCnt >= divTerm(s_q.prescale)) begin
                s_d.preCnt = 10'h000;
                dispTick = 1'b1;
            end else begin
                s_d.preCnt = s_q.preCnt + 10'd1;
            end
        end
        // [R4] one period per common
        if (dispTick) begin
            if ({1'b0, s_q.phase} >= nCom - 3'd1) begin
                s_d.phase = 2'h0;
                s_d.frameInv = ~s_q.frameInv;
            end else begin
                s_d.phase = s_q.phase + 2'd1;
            end
        end

        // [R16] commons fixed by mode
        for (int c = 0; c < 4; c++) begin
            if (s_q.run == LSD_RUN_OFF || 3'(c) >= nCom) begin
                // [R18] unused commons float
                s_d.comOe[c] = 1'b0;
                s_d.comLvl[c*2 +: 2] = LSD_LVL_V0;
            end else if (s_q.run == LSD_RUN_HALT) begin
                s_d.comOe[c] = 1'b1;
                s_d.comLvl[c*2 +: 2] = LSD_LVL_V0;
            end else begin
                // [R15] levels per bias
                s_d.comOe[c] = 1'b1;
                s_d.comLvl[c*2 +: 2] = comLevel(s_q.phase == 2'(c), s_q.frameInv, bias);
            end
        end

        for (int i = 0; i < 40; i++) begin
            // [R11] gated by display_on
            // [R12] enable acts at once
            segEnabled = s_q.displayOn & s_q.segEn[i];
            phaseBase = 8'(i * 4);
            // [R17] bit for current common
            segBit = s_q.ram[phaseBase + {6'h00, s_q.phase}];
            if (!segEnabled) begin
                // [R23] disabled line floats
                s_d.segOe[i] = 1'b0;
                s_d.segLvl[i*2 +: 2] = LSD_LVL_V0;
            end else if (s_q.run != LSD_RUN_ACTIVE) begin
                // [R20] enabled pins pulled low
                s_d.segOe[i] = 1'b1;
                s_d.segLvl[i*2 +: 2] = LSD_LVL_V0;
            end else begin
                // [R5] on waveform
                // [R6] off waveform
                s_d.segOe[i] = 1'b1;
                s_d.segLvl[i*2 +: 2] = segLevel(segBit, s_q.frameInv, bias);
            end
        end
    end

    // [R1] default mode at reset
    // [R2] enables cleared, pins float
    // [R10] memory content not relied on
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= LSD_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdData;
    assign ack_o = s_q.ack;
    assign segmentLinesLvl = s_q.segLvl;
    assign segmentLinesOe = s_q.segOe;
    assign commonLinesLvl = s_q.comLvl;
    assign commonLinesOe = s_q.comOe;

endmodule

`default_nettype wire
